// file: diag_pkg.sv
// shared constants and carrier types for the serial diagnostic status node
package diag_pkg;

  // response byte layout
  localparam int RSP_OUT_EN      = 0;
  localparam int RSP_ACT_SEEN    = 1;
  localparam int RSP_IN_ENERGY   = 4;
  localparam int RSP_LIMIT_AREA  = 5;
  localparam int RSP_WARN        = 6;
  localparam int RSP_FAIL        = 7;

  // cause byte layout, shared by warning and failure bytes
  localparam int CAUSE_OUT_A     = 0;
  localparam int CAUSE_OUT_B     = 1;
  localparam int CAUSE_CROSS     = 2;
  localparam int CAUSE_TEMP      = 3;
  localparam int CAUSE_ACT_CODE  = 4;
  localparam int CAUSE_INTERNAL  = 5;
  localparam int CAUSE_COMM      = 6;

  // request byte layout
  localparam int REQ_FAIL_RESET  = 7;

  // chain limits
  localparam int MAX_NODES       = 31;

  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // escalation delay: 30 minutes at 200 MHz
  localparam longint ESC_MINUTES   = 30;
  localparam longint CLK_HZ        = 200000000;
  localparam longint ESC_CYCLES    = ESC_MINUTES * 64'd60 * CLK_HZ;
  localparam int     ESC_CNT_W     = 39;

  // detected conditions from the sensing front end
  typedef struct packed {
    logic act_present;
    logic act_valid;
    logic limit_area;
    logic err_out_a;
    logic err_out_b;
    logic cross_wire;
    logic over_temp;
    logic internal_err;
    logic comm_err;
  } sense_t;

  // the three bytes reported toward the gateway
  typedef struct packed {
    logic [7:0] response;
    logic [7:0] warning;
    logic [7:0] failure;
  } report_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WARN = 3'b010,
    ST_FAIL = 3'b100
  } fault_state_t;

endpackage

// file: escalation_timer.sv
// failure-warning escalation timer
`timescale 1ns/10ps
module escalation_timer #(
  parameter int                 W      = diag_pkg::ESC_CNT_W,
  parameter logic [W-1:0]       LIMIT  = W'(diag_pkg::ESC_CYCLES)
) (
  // clocking
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // control
  input  wire logic run,
  output logic      expired
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // count restarts whenever run drops
  always_comb begin
    cnt_d = cnt_q;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q != LIMIT) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = run && (cnt_q == LIMIT);

endmodule // escalation_timer

// file: gw_model.sv
// gateway side model that issues request bytes
`timescale 1ns/10ps
module gw_model (
  // clocking
  input wire logic   mclk,
  // request toward the node
  output logic [7:0] req_byte,
  output logic       req_valid
);
  initial begin
    req_byte = 8'h00;
    req_valid = 1'b0;
  end
  // one-cycle strobe; byte scrambled after so stale data never looks valid
  task automatic issue(input logic [7:0] b);
    @(negedge mclk);
    req_byte = b;
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    req_byte = ~b;
  endtask
endmodule // gw_model

// file: node_props.sv
// concurrent checks on the status node ports
`timescale 1ns/10ps
module node_props (
  // clocking
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              ce,
  // pins and requests
  input wire logic [4:0]        node_index,
  input wire logic              safety_in_a,
  input wire logic              safety_in_b,
  input wire logic [7:0]        host_request_byte,
  input wire logic              host_request_valid,
  // results
  input wire logic              safety_out_a,
  input wire logic              safety_out_b,
  input wire diag_pkg::report_t report,
  input wire logic              node_index_ok
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire clr = host_request_valid && host_request_byte[7];
  ////////////////////////////////////////////////////////////////////////////////
  a_fail_outs_off: assert property (
    report.response[7] |-> !safety_out_a && !report.response[0])
    else $error("outputs on in failure");
  a_outs_agree: assert property (safety_out_a == safety_out_b)
    else $error("safety outputs differ");
  a_warn_outs_on: assert property (
    report.response[6] |-> report.response[0] && !report.response[7])
    else $error("warning without outputs on");
  a_index_range: assert property (
    ce |=> node_index_ok == ($past(node_index) < 5'h1F))
    else $error("index flag wrong");
  a_inputs_seen: assert property (
    (ce && safety_in_a && safety_in_b)[*5] |-> report.response[4])
    else $error("energised inputs not shown");
  a_inputs_off: assert property (
    (ce && !safety_in_a)[*5] |-> !report.response[4] && !safety_out_a)
    else $error("dead input shown as energised");
  a_fail_latched: assert property (
    report.response[7] && !clr && !$past(clr) |=> report.response[7])
    else $error("failure dropped without reset");
  a_rst_quiet: assert property (disable iff (1'b0)
    rst |=> report == 24'h000000 && !safety_out_b && !node_index_ok)
    else $error("report not cleared by reset");
endmodule // node_props

// file: serial_diag_status_node.sv
// status and diagnostic byte logic of one node in a serial diagnostic chain
`timescale 1ns/10ps
module serial_diag_status_node #(
  parameter int                    ESC_W     = diag_pkg::ESC_CNT_W,
  parameter logic [ESC_W-1:0]      ESC_LIMIT = ESC_W'(diag_pkg::ESC_CYCLES),
  parameter int                    NODE_ID_W = 5
) (
  // clocking
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // node position in the chain, 0 to 30
  input  wire logic [NODE_ID_W-1:0]   node_index,
  // safety inputs from the previous node, pins
  input  wire logic                   safety_in_a,
  input  wire logic                   safety_in_b,
  // sensing front end conditions, pins
  input  wire diag_pkg::sense_t       sense,
  // request byte from the gateway, decoded line data on mclk
  input  wire logic [7:0]             host_request_byte,
  input  wire logic                   host_request_valid,
  // safety outputs toward next node
  output logic                        safety_out_a,
  output logic                        safety_out_b,
  // report toward the gateway
  output diag_pkg::report_t           report,
  output logic                        node_index_ok
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [1:0]       in_s;
  diag_pkg::sense_t sense_s;

  sync2 #(.W(2)) u_sync_in (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .d    ({safety_in_b, safety_in_a}),
    .q    (in_s)
  );

  sync2 #(.W($bits(diag_pkg::sense_t))) u_sync_sense (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .d    (sense),
    .q    (sense_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // derived conditions

  logic inputs_on;
  logic act_ok;
  logic [7:0] cause_now;
  logic warn_cause;
  logic fail_cause;

  logic idx_ok_q;
  logic idx_ok_d;

  // positions beyond the chain limit are flagged, not rejected
  always_comb begin
    idx_ok_d = (32'(node_index) < diag_pkg::MAX_NODES);
  end

  // flag is a data output, so it leaves from a flip-flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      idx_ok_q <= 1'b0;
    end else if (ce) begin
      idx_ok_q <= idx_ok_d;
    end
  end

  assign inputs_on = in_s[0] && in_s[1];
  assign act_ok    = sense_s.act_present && sense_s.act_valid;

  always_comb begin
    cause_now = 8'h00;
    cause_now[diag_pkg::CAUSE_OUT_A]    = sense_s.err_out_a;
    cause_now[diag_pkg::CAUSE_OUT_B]    = sense_s.err_out_b;
    cause_now[diag_pkg::CAUSE_CROSS]    = sense_s.cross_wire;
    cause_now[diag_pkg::CAUSE_TEMP]     = sense_s.over_temp;
    cause_now[diag_pkg::CAUSE_INTERNAL] = sense_s.internal_err;
  end

  // internal and actuator faults shut off at once; the rest warn first
  assign fail_cause = sense_s.internal_err
                   || (sense_s.act_present && !sense_s.act_valid);
  assign warn_cause = sense_s.err_out_a || sense_s.err_out_b
                   || sense_s.cross_wire || sense_s.over_temp;

  ////////////////////////////////////////////////////////////////////////////
  // fault state machine

  diag_pkg::fault_state_t st_q;
  diag_pkg::fault_state_t st_d;
  logic [7:0] warn_q;
  logic [7:0] warn_d;
  logic [7:0] fail_q;
  logic [7:0] fail_d;
  logic       comm_q;
  logic       comm_d;
  logic       esc_expired;
  logic       reset_req;

  escalation_timer #(.W(ESC_W), .LIMIT(ESC_LIMIT)) u_esc (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .run     (st_q == diag_pkg::ST_WARN),
    .expired (esc_expired)
  );

  // other request bits carry no function and are ignored
  assign reset_req = host_request_valid
                  && host_request_byte[diag_pkg::REQ_FAIL_RESET];

  always_comb begin
    st_d   = st_q;
    warn_d = warn_q;
    fail_d = fail_q;
    // comm error is a live warning, not part of the escalation
    comm_d = sense_s.comm_err;
    case (st_q)
      diag_pkg::ST_IDLE: begin
        if (fail_cause) begin
          st_d   = diag_pkg::ST_FAIL;
          fail_d = cause_now;
          fail_d[diag_pkg::CAUSE_ACT_CODE] = sense_s.act_present
                                          && !sense_s.act_valid;
        end else if (warn_cause) begin
          st_d   = diag_pkg::ST_WARN;
          warn_d = cause_now;
        end
      end
      diag_pkg::ST_WARN: begin
        warn_d = cause_now;
        if (fail_cause) begin
          st_d   = diag_pkg::ST_FAIL;
          fail_d = cause_now;
          fail_d[diag_pkg::CAUSE_ACT_CODE] = sense_s.act_present
                                          && !sense_s.act_valid;
        end else if (esc_expired) begin
          st_d   = diag_pkg::ST_FAIL;
          fail_d = warn_q;
          warn_d = 8'h00;
        end else if (!warn_cause) begin
          // cause rectified before the delay ran out
          st_d   = diag_pkg::ST_IDLE;
          warn_d = 8'h00;
        end
      end
      diag_pkg::ST_FAIL: begin
        // new causes other than the actuator code still accumulate while latched; set wins over clear
        fail_d = fail_q | cause_now;
        if (reset_req && !fail_cause && !warn_cause) begin
          st_d   = diag_pkg::ST_IDLE;
          fail_d = 8'h00;
          warn_d = 8'h00;
        end
      end
      default: begin
        st_d = diag_pkg::ST_FAIL;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q   <= diag_pkg::ST_IDLE;
      warn_q <= diag_pkg::BYTE_RESET;
      fail_q <= diag_pkg::BYTE_RESET;
      comm_q <= 1'b0;
    end else if (ce) begin
      st_q   <= st_d;
      warn_q <= warn_d;
      fail_q <= fail_d;
      comm_q <= comm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and report bytes

  logic               out_en;
  logic               out_q;
  logic               out_d;
  diag_pkg::report_t  rep_q;
  diag_pkg::report_t  rep_d;

  // outputs released only when actuated, inputs live and no failure
  assign out_en = act_ok && inputs_on && (st_q != diag_pkg::ST_FAIL);

  always_comb begin
    out_d = out_en;
    rep_d = '0;
    rep_d.response[diag_pkg::RSP_OUT_EN]     = out_en;
    rep_d.response[diag_pkg::RSP_ACT_SEEN]   = act_ok;
    rep_d.response[diag_pkg::RSP_IN_ENERGY]  = inputs_on;
    rep_d.response[diag_pkg::RSP_LIMIT_AREA] = act_ok && sense_s.limit_area;
    rep_d.response[diag_pkg::RSP_WARN]       = (st_q == diag_pkg::ST_WARN)
                                            && out_en;
    rep_d.response[diag_pkg::RSP_FAIL]       = (st_q == diag_pkg::ST_FAIL);
    rep_d.warning = warn_q;
    rep_d.warning[diag_pkg::CAUSE_COMM]      = comm_q;
    rep_d.failure = fail_q;
  end

  // refreshed every enabled cycle with no request needed
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_q <= 1'b0;
      rep_q <= '0;
    end else if (ce) begin
      out_q <= out_d;
      rep_q <= rep_d;
    end
  end

  assign safety_out_a = out_q;
  assign safety_out_b = out_q;
  assign report       = rep_q;
  assign node_index_ok = idx_ok_q;

endmodule // serial_diag_status_node

// file: sync2.sv
// two-stage synchroniser, one per bit
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  // clocking
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = ce ? d : meta_q;
    q_d    = ce ? meta_q : q;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end

endmodule // sync2

// file: tb.sv
// self-checking bench for the serial diagnostic status node
`timescale 1ns/10ps
module tb;
  logic              mclk;
  logic              rst;
  logic              ce;
  logic [4:0]        node_index;
  logic              in_a;
  logic              in_b;
  diag_pkg::sense_t  sense;
  logic [7:0]        req_byte;
  logic              req_valid;
  logic              out_a;
  logic              out_b;
  diag_pkg::report_t report;
  logic              idx_ok;
  logic              idx_want;
  int                failures;
  int                n_tests;
  int                k;
  localparam logic [8:0] ROW_S [8] = '{9'h000, 9'h180, 9'h1C0, 9'h1A0, 9'h180, 9'h190, 9'h184,
                                       9'h181};
  localparam logic [7:0] ROW_R [8] = '{8'h00, 8'h13, 8'h33, 8'h53, 8'h13, 8'h53, 8'h53, 8'h13};
  localparam logic [7:0] ROW_W [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h08, 8'h40};
  localparam logic [8:0] CAUSE_S [3] = '{9'h188, 9'h182, 9'h100};
  localparam logic [7:0] CAUSE_F [3] = '{8'h04, 8'h20, 8'h10};

  // escalation shortened to 20 cycles
  serial_diag_status_node #(.ESC_W(39), .ESC_LIMIT(39'd20)) dut (
    .mclk(mclk), .rst(rst), .ce(ce), .node_index(node_index),
    .safety_in_a(in_a), .safety_in_b(in_b), .sense(sense),
    .host_request_byte(req_byte), .host_request_valid(req_valid),
    .safety_out_a(out_a), .safety_out_b(out_b), .report(report), .node_index_ok(idx_ok));
  gw_model gw (.mclk(mclk), .req_byte(req_byte), .req_valid(req_valid));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rsp(input logic f, input logic w, input logic l, input logic a);
    return {f, w, l & a, 1'b1, 2'b00, a, a & ~f};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input logic [8:0] s, input int n);
    @(negedge mclk);
    sense = diag_pkg::sense_t'(s);
    node_index = 5'($urandom);
    // flag is registered and frozen while ce is low
    if (ce) idx_want = (node_index < 5'h1F);
    repeat (n) @(negedge mclk);
  endtask
  task automatic look(input logic [7:0] r, input logic [7:0] w, input logic [7:0] f);
    chk("response", r, report.response);
    chk("warning", w, report.warning);
    chk("failure", f, report.failure);
    chk("outputs", {6'h00, r[0], r[0]}, {6'h00, out_b, out_a});
    chk("index ok", {7'h00, idx_want}, {7'h00, idx_ok});
  endtask
  task automatic final_report();
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // run needs about 263 cycles
  initial begin
    #10000;
    failures++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    node_index = 5'h00;
    in_a = 1'b0;
    in_b = 1'b0;
    sense = diag_pkg::sense_t'(9'h000);
    failures = 0;
    n_tests = 0;
    idx_want = 1'b0;
    k = $urandom(19582);
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    for (k = 0; k < 8; k++) begin
      if (k == 1) begin
        in_a = 1'b1;
        in_b = 1'b1;
      end
      settle(ROW_S[k], 8);
      look(ROW_R[k], ROW_W[k], 8'h00);
    end
    ce = 1'b0;
    settle(9'h000, 6);
    look(8'h13, 8'h40, 8'h00);
    ce = 1'b1;
    for (k = 0; k < 3; k++) begin
      settle(CAUSE_S[k], 36);
      look(rsp(1'b1, 1'b0, 1'b0, 1'(k != 2)), 8'h00, CAUSE_F[k]);
      gw.issue(8'h80);
      gw.issue(8'($urandom) & 8'h7F);
      settle(CAUSE_S[k], 4);
      look(rsp(1'b1, 1'b0, 1'b0, 1'(k != 2)), 8'h00, CAUSE_F[k]);
      settle(9'h180, 6);
      gw.issue(8'h80);
      settle(9'h180, 4);
      look(rsp(1'b0, 1'b0, 1'b0, 1'b1), 8'h00, 8'h00);
    end
    final_report();
  end
endmodule // tb

bind serial_diag_status_node node_props props_i (
  .mclk(mclk), .rst(rst), .ce(ce), .node_index(node_index),
  .safety_in_a(safety_in_a), .safety_in_b(safety_in_b),
  .host_request_byte(host_request_byte), .host_request_valid(host_request_valid),
  .safety_out_a(safety_out_a), .safety_out_b(safety_out_b),
  .report(report), .node_index_ok(node_index_ok));
